/* File: include/pllcfg_regs.svh */
// Register map, field positions, reset values and timing counts for the clock configuration block
`ifndef PLLCFG_REGS_SVH
`define PLLCFG_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PLLC_ADDR_W        8
`define PLLC_OFS_CFG       8'h00
`define PLLC_OFS_CTRL      8'h04
`define PLLC_OFS_STATUS    8'h08

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PLLC_CFG_W         8
`define PLLC_CFG_RST       8'h00
`define PLLC_CTRL_OE_BIT   0
`define PLLC_CTRL_RST      1'h1
`define PLLC_ST_NUM_LSB    0
`define PLLC_ST_BADCFG_BIT 3
`define PLLC_ST_BADFB_BIT  4
`define PLLC_ST_HALF_BIT   5
`define PLLC_ST_LOCK_BIT   6
`define PLLC_ST_TICK_LSB   8

// ----------------------------------------------------------------------
// Output counts per configuration (double, base); rest run at half rate
// ----------------------------------------------------------------------
`define PLLC_NUM_OUT       14
`define PLLC_C1_DBL        5'h02
`define PLLC_C1_BASE       5'h0C
`define PLLC_C2_DBL        5'h02
`define PLLC_C2_BASE       5'h04
`define PLLC_C3_DBL        5'h04
`define PLLC_C3_BASE       5'h0A
`define PLLC_C4_DBL        5'h00
`define PLLC_C4_BASE       5'h0E
`define PLLC_C5_DBL        5'h00
`define PLLC_C5_BASE       5'h07
`define PLLC_C6_DBL        5'h02
`define PLLC_C6_BASE       5'h0C

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PLLC_CNT_W         4
`define PLLC_SETTLE_CYC    5'h10

`endif

/* File: include/pllcfg_pkg.sv */
// Types shared by the clock configuration block
package pllcfg_pkg;

  typedef enum logic [1:0] {
    PLLC_RATE_DBL  = 2'b00,
    PLLC_RATE_BASE = 2'b01,
    PLLC_RATE_HALF = 2'b10
  } pllcfg_rate_t;

  typedef enum logic [1:0] {
    PLLC_FB_Q4 = 2'b00,
    PLLC_FB_Q2 = 2'b01,
    PLLC_FB_Q  = 2'b11
  } pllcfg_fb_t;

  typedef struct packed {
    logic [2:0] phase_sel;
    logic [1:0] fb_ratio_sel;
    logic [2:0] out_cfg_sel;
  } pllcfg_sel_t;

  typedef struct packed {
    logic dbl;
    logic base;
    logic half;
    logic phase;
    logic loop;
  } pllcfg_clk_t;

endpackage

/* File: design/pllcfg_tap.sv */
// Registered tap of the shared divider count, shifted back by a number of ticks
`timescale 1ns/1ps
`default_nettype none
`include "pllcfg_regs.svh"

module pllcfg_tap
  import pllcfg_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [`PLLC_CNT_W-1:0] cnt,
  input  wire logic [`PLLC_CNT_W-1:0] shift,
  input  wire logic [1:0]             bit_sel,
  output logic                        tap_r
);

  logic [`PLLC_CNT_W-1:0] delayed;
  logic                   tap_nxt;

  // Subtracting the shift delays the waveform by whole VCO ticks
  always_comb begin
    delayed = cnt - shift;
    tap_nxt = delayed[bit_sel];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tap_r <= 1'b0;
    end else begin
      tap_r <= tap_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: design/pllcfg_top.sv */
// Output configuration, feedback ratio and phase step select with APB registers
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pllcfg_regs.svh"

module pllcfg_top
  import pllcfg_pkg::*;
(
  input  wire logic                     CORE_CLK,
  input  wire logic                     SYS_RST,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [`PLLC_ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  output logic [`PLLC_NUM_OUT-1:0]      PROG_CLK_OUT,
  output logic                          PROG_OE_N,
  output logic                          DOUBLE_RATE_CLK_OUT,
  output logic                          DOUBLE_RATE_OE_N,
  output logic                          PHASE_CLK_OUT,
  output logic                          PHASE_OE_N,
  output logic                          LOOP_RETURN_OUT,
  output logic                          LOCK_OUT
);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  pllcfg_sel_t cfg_r;
  pllcfg_sel_t cfg_nxt;
  logic        oe_r;
  logic        oe_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] status;
  logic        setup;
  logic        access;
  logic        mapped;
  logic        cfg_wr;

  always_comb begin
    setup  = PSEL && !PENABLE;
    access = PSEL && PENABLE;
    mapped = (PADDR == `PLLC_OFS_CFG) || (PADDR == `PLLC_OFS_CTRL) ||
             (PADDR == `PLLC_OFS_STATUS);
    cfg_wr = access && PWRITE && (PADDR == `PLLC_OFS_CFG);
  end

  // Zero wait states; read data is captured in setup so it comes from a flop
  always_comb begin
    PREADY  = 1'b1;
    PSLVERR = access && !mapped;
    cfg_nxt = cfg_r;
    oe_nxt  = oe_r;
    rdata_nxt = rdata_r;
    if (cfg_wr) begin
      cfg_nxt = pllcfg_sel_t'(PWDATA[`PLLC_CFG_W-1:0]);
    end
    if (access && PWRITE && (PADDR == `PLLC_OFS_CTRL)) begin
      oe_nxt = PWDATA[`PLLC_CTRL_OE_BIT];
    end
    if (setup && !PWRITE) begin
      unique case (PADDR)
        `PLLC_OFS_CFG:    rdata_nxt = {24'h000000, cfg_r};
        `PLLC_OFS_CTRL:   rdata_nxt = {31'h00000000, oe_r};
        `PLLC_OFS_STATUS: rdata_nxt = status;
        default:          rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cfg_r   <= pllcfg_sel_t'(`PLLC_CFG_RST);
      oe_r    <= `PLLC_CTRL_RST;
      rdata_r <= 32'h00000000;
    end else begin
      cfg_r   <= cfg_nxt;
      oe_r    <= oe_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign PRDATA = rdata_r;

  // ----------------------------------------------------------------------
  // Select decode
  // ----------------------------------------------------------------------
  logic [2:0]             cfg_num;
  logic [4:0]             n_dbl;
  logic [4:0]             n_base;
  logic                   bad_cfg;
  logic                   bad_fb;
  pllcfg_fb_t             fb_mode;
  logic                   half_phase;
  logic [`PLLC_CNT_W-1:0] ph_ticks;
  pllcfg_rate_t           rate [`PLLC_NUM_OUT];

  always_comb begin
    bad_cfg = 1'b0;
    unique case (cfg_r.out_cfg_sel)
      3'h0: begin cfg_num = 3'h1; n_dbl = `PLLC_C1_DBL; n_base = `PLLC_C1_BASE; end
      3'h1: begin cfg_num = 3'h2; n_dbl = `PLLC_C2_DBL; n_base = `PLLC_C2_BASE; end
      3'h2: begin cfg_num = 3'h3; n_dbl = `PLLC_C3_DBL; n_base = `PLLC_C3_BASE; end
      3'h3: begin cfg_num = 3'h4; n_dbl = `PLLC_C4_DBL; n_base = `PLLC_C4_BASE; end
      3'h4: begin cfg_num = 3'h5; n_dbl = `PLLC_C5_DBL; n_base = `PLLC_C5_BASE; end
      3'h7: begin cfg_num = 3'h6; n_dbl = `PLLC_C6_DBL; n_base = `PLLC_C6_BASE; end
      default: begin
        cfg_num = 3'h1;
        n_dbl   = `PLLC_C1_DBL;
        n_base  = `PLLC_C1_BASE;
        bad_cfg = 1'b1;
      end
    endcase
    bad_fb = 1'b0;
    unique case (cfg_r.fb_ratio_sel)
      2'b00:   fb_mode = PLLC_FB_Q4;
      2'b01:   fb_mode = PLLC_FB_Q2;
      2'b11:   fb_mode = PLLC_FB_Q;
      default: begin
        fb_mode = PLLC_FB_Q2;
        bad_fb  = 1'b1;
      end
    endcase
    // Phase output follows the rate of the configuration's slowest set
    half_phase = (cfg_num == 3'h2) || (cfg_num == 3'h5);
    if (half_phase) begin
      ph_ticks = {1'b0, cfg_r.phase_sel + 3'h1};
    end else begin
      unique case (cfg_r.phase_sel[1:0])
        2'b00: ph_ticks = 4'h2;
        2'b01: ph_ticks = 4'h1;
        2'b10: ph_ticks = 4'h0;
        2'b11: ph_ticks = 4'h3;
      endcase
    end
  end

  // Lowest indices run fastest: double, then base, then half
  always_comb begin
    for (int i = 0; i < `PLLC_NUM_OUT; i++) begin
      if (5'(i) < n_dbl) begin
        rate[i] = PLLC_RATE_DBL;
      end else if (5'(i) < n_dbl + n_base) begin
        rate[i] = PLLC_RATE_BASE;
      end else begin
        rate[i] = PLLC_RATE_HALF;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------------
  // One counter feeds every tap, so all rates share the same edges
  logic [`PLLC_CNT_W-1:0] cnt_r;
  logic [`PLLC_CNT_W-1:0] cnt_nxt;
  logic [1:0]             loop_bit;
  logic [1:0]             phase_bit;
  pllcfg_clk_t            tap;

  always_comb begin
    cnt_nxt = cnt_r + 4'h1;
    unique case (fb_mode)
      PLLC_FB_Q4: loop_bit = 2'h3;
      PLLC_FB_Q2: loop_bit = 2'h2;
      PLLC_FB_Q:  loop_bit = 2'h1;
      default:    loop_bit = 2'h2;
    endcase
    phase_bit = half_phase ? 2'h2 : 2'h1;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  pllcfg_tap u_tap_dbl (.clk(CORE_CLK), .rst(SYS_RST), .cnt(cnt_r), .shift(4'h0),
                        .bit_sel(2'h0), .tap_r(tap.dbl));
  pllcfg_tap u_tap_base (.clk(CORE_CLK), .rst(SYS_RST), .cnt(cnt_r), .shift(4'h0),
                         .bit_sel(2'h1), .tap_r(tap.base));
  pllcfg_tap u_tap_half (.clk(CORE_CLK), .rst(SYS_RST), .cnt(cnt_r), .shift(4'h0),
                         .bit_sel(2'h2), .tap_r(tap.half));
  pllcfg_tap u_tap_phase (.clk(CORE_CLK), .rst(SYS_RST), .cnt(cnt_r), .shift(ph_ticks),
                          .bit_sel(phase_bit), .tap_r(tap.phase));
  pllcfg_tap u_tap_loop (.clk(CORE_CLK), .rst(SYS_RST), .cnt(cnt_r), .shift(4'h0),
                         .bit_sel(loop_bit), .tap_r(tap.loop));

  // ----------------------------------------------------------------------
  // Output stage and lock
  // ----------------------------------------------------------------------
  pllcfg_clk_t              out_r;
  logic [`PLLC_NUM_OUT-1:0] prog_r;
  logic [`PLLC_NUM_OUT-1:0] prog_nxt;
  logic [4:0]               settle_r;
  logic [4:0]               settle_nxt;
  logic                     lock_r;
  logic                     lock_nxt;

  // Equal pipeline depth on every pin keeps output-to-output skew at zero
  always_comb begin
    for (int i = 0; i < `PLLC_NUM_OUT; i++) begin
      unique case (rate[i])
        PLLC_RATE_DBL:  prog_nxt[i] = tap.dbl;
        PLLC_RATE_BASE: prog_nxt[i] = tap.base;
        default:        prog_nxt[i] = tap.half;
      endcase
    end
    // Any config write restarts the settle count and drops lock
    if (cfg_wr) begin
      settle_nxt = 5'h00;
    end else if (settle_r != `PLLC_SETTLE_CYC) begin
      settle_nxt = settle_r + 5'h01;
    end else begin
      settle_nxt = settle_r;
    end
    lock_nxt = !cfg_wr && (settle_r == `PLLC_SETTLE_CYC);
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      out_r    <= '0;
      prog_r   <= '0;
      settle_r <= 5'h00;
      lock_r   <= 1'b0;
    end else begin
      out_r    <= tap;
      prog_r   <= prog_nxt;
      settle_r <= settle_nxt;
      lock_r   <= lock_nxt;
    end
  end

  // Loop return and lock have no enable: the loop must keep closing
  always_comb begin
    PROG_CLK_OUT        = prog_r;
    DOUBLE_RATE_CLK_OUT = out_r.dbl;
    PHASE_CLK_OUT       = out_r.phase;
    LOOP_RETURN_OUT     = out_r.loop;
    LOCK_OUT            = lock_r;
    PROG_OE_N           = !oe_r;
    DOUBLE_RATE_OE_N    = !oe_r;
    PHASE_OE_N          = !oe_r;
    status = 32'h00000000;
    status[`PLLC_ST_NUM_LSB +: 3]   = cfg_num;
    status[`PLLC_ST_BADCFG_BIT]     = bad_cfg;
    status[`PLLC_ST_BADFB_BIT]      = bad_fb;
    status[`PLLC_ST_HALF_BIT]       = half_phase;
    status[`PLLC_ST_LOCK_BIT]       = lock_r;
    status[`PLLC_ST_TICK_LSB +: 4]  = ph_ticks;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  // Outputs trail the counter by two edges; the double-rate output first toggles three edges after reset
  a_dbl_toggles: assert property (
    !$past(SYS_RST) && !$past(SYS_RST, 2) && !$past(SYS_RST, 3) |->
      DOUBLE_RATE_CLK_OUT != $past(DOUBLE_RATE_CLK_OUT))
    else $error("double rate output did not toggle");

  a_base_edge_align: assert property (
    $changed(out_r.base) |-> $fell(DOUBLE_RATE_CLK_OUT))
    else $error("base output moved off a double rate edge");

  a_half_period: assert property (
    $rose(out_r.half) |-> ##8 $rose(out_r.half))
    else $error("half rate period is not eight ticks");

  // A config write mid-period drops lock and ends the check
  a_fb_quarter: assert property (
    (lock_r && fb_mode == PLLC_FB_Q4 && $rose(LOOP_RETURN_OUT)) |->
      ##8 (!LOOP_RETURN_OUT || !lock_r) ##8 ($rose(LOOP_RETURN_OUT) || !lock_r))
    else $error("loop return not at quarter of base rate");

  a_phase_zero: assert property (
    (lock_r && !half_phase && cfg_r.phase_sel[1:0] == 2'b10) |-> PHASE_CLK_OUT == out_r.base)
    else $error("zero degree phase differs from base");

  a_phase_opposite: assert property (
    (lock_r && !half_phase && cfg_r.phase_sel[1:0] == 2'b00) |-> PHASE_CLK_OUT != out_r.base)
    else $error("180 degree phase not inverted");

  a_half_full_turn: assert property (
    (lock_r && half_phase && cfg_r.phase_sel == 3'h7) |-> PHASE_CLK_OUT == out_r.half)
    else $error("360 degree half rate phase differs");

  a_half_step_lag: assert property (
    (lock_r && half_phase && cfg_r.phase_sel == 3'h0) |-> PHASE_CLK_OUT == $past(out_r.half))
    else $error("45 degree step is not one tick");

  a_cfg_five_map: assert property (
    (cfg_r.out_cfg_sel == 3'h4) |-> ##1 (prog_r[6] == out_r.base && prog_r[13] == out_r.half))
    else $error("configuration five output split wrong");

  a_bad_default: assert property (
    (cfg_r.out_cfg_sel == 3'h6) |-> (status[2:0] == 3'h1 && status[`PLLC_ST_BADCFG_BIT]))
    else $error("unlisted select not mapped to default");

  a_loop_no_oe: assert property (
    !oe_r && $rose(out_r.dbl) |-> ##[1:16] $changed(LOOP_RETURN_OUT))
    else $error("loop return stopped while outputs disabled");

endmodule
`default_nettype wire

/* File: tb/pllcfg_cpu_model.sv */
// Processor clock input model that samples two clock enables
`timescale 1ns/1ps
`default_nettype none

module pllcfg_cpu_model (
  input  wire logic       cpu_double_clk_in,
  input  wire logic       pclk_en,
  input  wire logic       bclk_en,
  output logic [1:0]      en_smp,
  output logic [1:0]      en_prev
);
  // ----------------------------------------------------------------------
  // Enable capture
  // ----------------------------------------------------------------------
  // Taken on the rising double-rate edge only, as the processor does
  always @(posedge cpu_double_clk_in) begin
    en_prev <= en_smp;
    en_smp  <= {bclk_en, pclk_en};
  end
endmodule
`default_nettype wire

/* File: tb/pllcfg_top_tb.sv */
// Self-checking bench for the clock configuration block
`timescale 1ns/1ps
`default_nettype none
`include "pllcfg_regs.svh"

module pllcfg_top_tb
  import pllcfg_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [13:0] prog;
  logic        prog_oe_n;
  logic        dbl;
  logic        dbl_oe_n;
  logic        ph;
  logic        ph_oe_n;
  logic        loopo;
  logic        lock;
  logic [1:0]  en_smp;
  logic [1:0]  en_prev;
  int          n_errors = 0;
  int          num_checks = 0;
  logic [31:0] rd;
  logic        err;
  logic [13:0] h_prog [24];
  logic        h_dbl [24];
  logic        h_ph [24];
  logic        h_loop [24];
  logic [2:0]  num_t [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h1, 3'h6};
  logic [4:0]  dbl_t [8] = '{5'h02, 5'h02, 5'h04, 5'h00, 5'h00, 5'h02, 5'h02, 5'h02};
  logic [4:0]  base_t [8] = '{5'h0C, 5'h04, 5'h0A, 5'h0E, 5'h07, 5'h0C, 5'h0C, 5'h0C};
  logic [3:0]  bt [4] = '{4'h2, 4'h1, 4'h0, 4'h3};
  logic [4:0]  fbt [4] = '{5'h02, 5'h04, 5'h04, 5'h08};

  pllcfg_top i_pllcfg_top (
    .CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PROG_CLK_OUT(prog), .PROG_OE_N(prog_oe_n), .DOUBLE_RATE_CLK_OUT(dbl),
    .DOUBLE_RATE_OE_N(dbl_oe_n), .PHASE_CLK_OUT(ph), .PHASE_OE_N(ph_oe_n),
    .LOOP_RETURN_OUT(loopo), .LOCK_OUT(lock)
  );

  // Enable for the bus clock comes from the delayed phase output
  pllcfg_cpu_model i_pllcfg_cpu_model (
    .cpu_double_clk_in(dbl), .pclk_en(prog[2]), .bclk_en(ph),
    .en_smp(en_smp), .en_prev(en_prev)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_errors++;
        test_done;
      end
      @(posedge clk);
    end
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  // Settle past the two-edge update, then record 24 settled samples
  task automatic cap;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 24; k++) begin
      @(negedge clk);
      h_prog[k] = prog;
      h_dbl[k]  = dbl;
      h_ph[k]   = ph;
      h_loop[k] = loopo;
    end
  endtask

  function automatic logic [4:0] loop_tog();
    logic [4:0] n;
    n = 5'h00;
    for (int k = 1; k <= 16; k++)
      n = n + 5'(h_loop[k] !== h_loop[k-1]);
    return n;
  endfunction

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial forever #2.5 clk = ~clk;

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    test_done;
  end

  initial begin
    logic [4:0] d, b, e, n;
    logic [3:0] t;
    int         bad;
    repeat (19) @(posedge clk);
    @(negedge clk);
    chk("clocks in reset", 32'h0, {prog, dbl, ph, loopo, lock});
    @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `PLLC_OFS_CFG, 32'h0);
    chk("cfg reset", 32'h0, rd);
    chk("mapped err", 32'h0, {31'h0, err});
    apb(1'b0, `PLLC_OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, 8'h10, 32'hFF);
    apb(1'b1, `PLLC_OFS_STATUS, 32'hFFFFFFFF);
    apb(1'b0, `PLLC_OFS_CFG, 32'h0);
    chk("cfg kept", 32'h0, rd);
    apb(1'b0, `PLLC_OFS_STATUS, 32'h0);
    chk("status ro", 32'h01, {27'h0, rd[4:0]});
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `PLLC_OFS_CFG, 32'h08 | c);
      apb(1'b0, `PLLC_OFS_STATUS, 32'h0);
      chk("cfg number", {28'h0, (c == 5 || c == 6), num_t[c]}, {28'h0, rd[3:0]});
      cap;
      d = dbl_t[c];
      b = base_t[c];
      for (int i = 0; i < 14; i++) begin
        n = 5'h00;
        for (int k = 1; k <= 16; k++)
          n = n + 5'(h_prog[k][i] !== h_prog[k-1][i]);
        e = (i < d) ? 5'h10 : ((i < d + b) ? 5'h08 : 5'h04);
        chk("output rate", {27'h0, e}, {27'h0, n});
      end
      bad = 0;
      for (int k = 1; k < 24; k++)
        if ((h_prog[k][d] !== h_prog[k-1][d] || h_prog[k][13] !== h_prog[k-1][13])
            && !(h_dbl[k-1] === 1'b1 && h_dbl[k] === 1'b0))
          bad++;
      chk("slow edge alignment", 32'h0, bad);
      if (c == 0)
        chk("cpu enable alternates", 32'h1, {31'h0, en_smp[0] !== en_prev[0]});
    end
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 8; s++) begin
        t = m ? 4'((s + 1) % 8) : bt[s % 4];
        apb(1'b1, `PLLC_OFS_CFG, 32'h08 | (s << 5) | m);
        apb(1'b0, `PLLC_OFS_STATUS, 32'h0);
        chk("phase status", {27'h0, t, m[0]}, {27'h0, rd[11:8], rd[5]});
        cap;
        bad = 0;
        for (int k = 8; k < 24; k++)
          if (h_ph[k] !== h_prog[k-t][m ? 6 : 2])
            bad++;
        chk("phase delay", 32'h0, bad);
      end
    end
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, `PLLC_OFS_CFG, f << 3);
      apb(1'b0, `PLLC_OFS_STATUS, 32'h0);
      chk("fb code flag", {31'h0, f == 2}, {31'h0, rd[4]});
      cap;
      chk("loop rate", {27'h0, fbt[f]}, {27'h0, loop_tog()});
    end
    apb(1'b1, `PLLC_OFS_CTRL, 32'h0);
    cap;
    chk("outputs off", 32'h7, {29'h0, prog_oe_n, dbl_oe_n, ph_oe_n});
    chk("loop runs", 32'h08, {27'h0, loop_tog()});
    chk("lock kept", 32'h1, {31'h0, lock});
    apb(1'b1, `PLLC_OFS_CTRL, 32'h1);
    cap;
    chk("outputs on", 32'h0, {29'h0, prog_oe_n, dbl_oe_n, ph_oe_n});
    apb(1'b1, `PLLC_OFS_CFG, 32'h08);
    repeat (2) @(negedge clk);
    chk("lock drop", 32'h0, {31'h0, lock});
    bad = 0;
    while (lock !== 1'b1 && bad < 100) begin
      @(negedge clk);
      bad++;
    end
    chk("lock settle", 32'h1, {31'h0, bad >= 12 && bad <= 18});
    test_done;
  end
endmodule
`default_nettype wire
